// file: logic/clock_gen_defines.svh
`ifndef CLOCK_GEN_DEFINES_SVH
`define CLOCK_GEN_DEFINES_SVH
// register addresses
`define ADDR_OSC_BUF        5'h0a
`define ADDR_SYNC_CTRL      5'h0b
`define ADDR_LOCK_PIN       5'h0c
`define ADDR_READBACK_GP0   5'h0d
`define ADDR_GP1            5'h0e
`define ADDR_LOOP_FILTER    5'h18
`define ADDR_CP_LOCK        5'h1a
`define ADDR_REF_DIV        5'h1c
`define ADDR_CAL_DIV        5'h1d
`define ADDR_FB_DIV         5'h1e
`define ADDR_WRITE_LOCK     5'h1f
`define ADDR_SOFT_RESET     5'h00
// field positions
`define SOFT_RESET_BIT      17
`define WRITE_LOCK_BIT      5
`define HOLD_SYNC_BIT       23
`define SYNC_POL_BIT        16
// word layout
`define WORD_BITS           32
`define ADDR_BITS           5
// reset values (data bits 31:5, address field reads zero)
`define RST_OSC_BUF         32'h8140_0000
`define RST_SYNC_CTRL       32'h0181_1000
`define RST_LOCK_PIN        32'h1b00_0000
`define RST_READBACK_GP0    32'h0302_0000
`define RST_GP1             32'h0800_0000
`define RST_LOOP_FILTER     32'h0000_0000
`define RST_CP_LOCK         32'h0c08_0000
`define RST_REF_DIV         32'h0040_0000
`define RST_CAL_DIV         32'h0700_0600
`define RST_FB_DIV          32'h0200_0600
`define RST_WRITE_LOCK      32'h0000_0000
`endif

// file: logic/clock_gen_pkg.sv
package clock_gen_pkg;
    typedef logic [31:0] word_t;
    typedef logic [4:0]  addr_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_APPLY = 2'b10
    } frame_state_e;
endpackage

// file: logic/serial_word_if.sv
`timescale 1ns/1ps
interface serial_word_if;
    logic [31:0] word;
    logic        valid;
    modport src (output word, output valid);
    modport dst (input word, input valid);
endinterface

// file: logic/serial_word_rx.sv
`timescale 1ns/1ps
module serial_word_rx (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  reset_n,
    // already synchronised serial pins
    input  wire logic  sclk_s,
    input  wire logic  sdata_s,
    input  wire logic  latch_s,
    // received word
    serial_word_if.src out
);
    logic        sclk_d_ff;
    logic        latch_d_ff;
    logic [31:0] shift_ff;
    clock_gen_pkg::frame_state_e state_ff;

    // edge detect on synchronised copies only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclk_d_ff  <= 1'b0;
            // latch idles high; a low reset value would fake an edge
            latch_d_ff <= 1'b1;
        end else begin
            sclk_d_ff  <= sclk_s;
            latch_d_ff <= latch_s;
        end
    end

    // msb first shift on rising data clock while latch is low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_ff <= 32'h0000_0000;
        end else if (sclk_s && !sclk_d_ff && !latch_s) begin
            shift_ff <= {shift_ff[30:0], sdata_s};
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= clock_gen_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                clock_gen_pkg::ST_IDLE: begin
                    if (!latch_s) begin
                        state_ff <= clock_gen_pkg::ST_SHIFT;
                    end
                end
                clock_gen_pkg::ST_SHIFT: begin
                    if (latch_s && !latch_d_ff) begin
                        state_ff <= clock_gen_pkg::ST_APPLY;
                    end
                end
                clock_gen_pkg::ST_APPLY: begin
                    state_ff <= clock_gen_pkg::ST_IDLE;
                end
                default: begin
                    state_ff <= clock_gen_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign out.word  = shift_ff;
    assign out.valid = (state_ff == clock_gen_pkg::ST_APPLY);
endmodule

// file: logic/clock_gen_upper_config_regs.sv
`timescale 1ns/1ps
`include "clock_gen_defines.svh"
// What this block does
// - secondary oscillator buffer enable resets off
// - primary oscillator buffer enable resets on
// - primary oscillator format resets to differential
// - oscillator path selects reset to bypass
// - six sync masks, pairs four/three set
// - sync polarity resets high, toggle syncs
// - crystal oscillator enable resets off
// - lock pin source select resets three
// - hold sync asserted until pll locks
// - loop filter fields all reset zero
// - reference doubler resets off
// - charge pump gain resets code three
// - lock only after count plus one stable ticks
// - reference divider one to 4095, default four
// - prescaler two to seven, default two
// - feedback divider one to 262143
// - write lock blocks registers zero to thirty
// - soft reset reloads every default
// - soft reset self clears on writes
module clock_gen_upper_config_regs (
    // clock and reset
    clk,
    reset_n,
    // serial write port pins
    ser_clk,
    ser_data,
    ser_latch,
    // pll status inputs on this clock
    pd_tick,
    phase_in_window,
    sync_request,
    // register contents
    osc_buffer_control,
    sync_and_osc_input_control,
    lock_detect_pin_control,
    readback_and_gp0_control,
    gp1_output_control,
    loop_filter_settings,
    charge_pump_and_lock_count,
    reference_divider,
    input_range_and_cal_divider,
    feedback_divider,
    write_lock_control,
    // derived controls
    soft_reset_active,
    digital_lock,
    sync_active,
    sw_sync_pulse,
    divider_config_error
);
    // clock and reset
    input  wire logic        clk;
    input  wire logic        reset_n;
    // serial write port pins
    input  wire logic        ser_clk;
    input  wire logic        ser_data;
    input  wire logic        ser_latch;
    // pll status inputs on this clock
    input  wire logic        pd_tick;
    input  wire logic        phase_in_window;
    input  wire logic        sync_request;
    // register contents
    output logic      [31:0] osc_buffer_control;
    output logic      [31:0] sync_and_osc_input_control;
    output logic      [31:0] lock_detect_pin_control;
    output logic      [31:0] readback_and_gp0_control;
    output logic      [31:0] gp1_output_control;
    output logic      [31:0] loop_filter_settings;
    output logic      [31:0] charge_pump_and_lock_count;
    output logic      [31:0] reference_divider;
    output logic      [31:0] input_range_and_cal_divider;
    output logic      [31:0] feedback_divider;
    output logic      [31:0] write_lock_control;
    // derived controls
    output logic             soft_reset_active;
    output logic             digital_lock;
    output logic             sync_active;
    output logic             sw_sync_pulse;
    output logic             divider_config_error;

    // synchroniser stages, stage two in bit one
    logic [1:0]  sclk_sync_ff;
    logic [1:0]  sdata_sync_ff;
    logic [1:0]  latch_sync_ff;

    // register storage
    logic [31:0] osc_buf_ff;
    logic [31:0] sync_ctrl_ff;
    logic [31:0] lock_pin_ff;
    logic [31:0] rb_gp0_ff;
    logic [31:0] gp1_ff;
    logic [31:0] loop_ff;
    logic [31:0] cp_lock_ff;
    logic [31:0] ref_div_ff;
    logic [31:0] cal_div_ff;
    logic [31:0] fb_div_ff;
    logic [31:0] wlock_ff;

    // soft reset, software sync and lock state
    logic        soft_rst_ff;
    logic        pol_d_ff;
    logic        sw_sync_ff;
    logic [13:0] lock_cnt_ff;
    logic        lock_ff;
    logic        div_err_ff;

    // write path
    logic        wr_en;
    logic        load_defaults;
    logic [4:0]  wr_addr;
    logic [31:0] wr_data;
    logic [13:0] lock_target;

    serial_word_if rx_bus ();

    // two stage synchronisers; only stage two feeds the receiver
    // latch stages reset to the idle high level of their pin
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclk_sync_ff  <= 2'b00;
            sdata_sync_ff <= 2'b00;
            latch_sync_ff <= 2'b11;
        end else begin
            sclk_sync_ff  <= {sclk_sync_ff[0], ser_clk};
            sdata_sync_ff <= {sdata_sync_ff[0], ser_data};
            latch_sync_ff <= {latch_sync_ff[0], ser_latch};
        end
    end

    serial_word_rx u_rx (
        .clk     (clk),
        .reset_n (reset_n),
        .sclk_s  (sclk_sync_ff[1]),
        .sdata_s (sdata_sync_ff[1]),
        .latch_s (latch_sync_ff[1]),
        .out     (rx_bus.src)
    );

    assign wr_addr = rx_bus.word[4:0];
    assign wr_data = {rx_bus.word[31:5], 5'b00000};

    // lock gates writes
    // the lock register itself stays writable so software can unlock
    assign wr_en = rx_bus.valid &&
                   (!wlock_ff[`WRITE_LOCK_BIT] ||
                    wr_addr == `ADDR_WRITE_LOCK);

    assign load_defaults = wr_en && wr_addr == `ADDR_SOFT_RESET &&
                           rx_bus.word[`SOFT_RESET_BIT];

    // soft reset flag clears
    // any accepted write other than a soft reset, mapped here or not, ends the soft reset state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            soft_rst_ff <= 1'b0;
        end else if (load_defaults) begin
            soft_rst_ff <= 1'b1;
        end else if (wr_en && wr_addr != `ADDR_SOFT_RESET) begin
            soft_rst_ff <= 1'b0;
        end else if (wr_en) begin
            soft_rst_ff <= 1'b0;
        end
    end

    // every register reloads on reset or soft reset and otherwise waits
    // for a word with its own address; other addresses fall through
    // secondary buffer off
    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            osc_buf_ff <= `RST_OSC_BUF;
        end else if (wr_en && wr_addr == `ADDR_OSC_BUF) begin
            osc_buf_ff <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            sync_ctrl_ff <= `RST_SYNC_CTRL;
        end else if (wr_en && wr_addr == `ADDR_SYNC_CTRL) begin
            sync_ctrl_ff <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            lock_pin_ff <= `RST_LOCK_PIN;
        end else if (wr_en && wr_addr == `ADDR_LOCK_PIN) begin
            lock_pin_ff <= wr_data;
        end
    end

    // readback pin type and first general output
    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            rb_gp0_ff <= `RST_READBACK_GP0;
        end else if (wr_en && wr_addr == `ADDR_READBACK_GP0) begin
            rb_gp0_ff <= wr_data;
        end
    end

    // second general output
    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            gp1_ff <= `RST_GP1;
        end else if (wr_en && wr_addr == `ADDR_GP1) begin
            gp1_ff <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            loop_ff <= `RST_LOOP_FILTER;
        end else if (wr_en && wr_addr == `ADDR_LOOP_FILTER) begin
            loop_ff <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            cp_lock_ff <= `RST_CP_LOCK;
        end else if (wr_en && wr_addr == `ADDR_CP_LOCK) begin
            cp_lock_ff <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            ref_div_ff <= `RST_REF_DIV;
        end else if (wr_en && wr_addr == `ADDR_REF_DIV) begin
            ref_div_ff <= wr_data;
        end
    end

    // calibration divider; the host keeps it equal to the feedback
    // divider, nothing here compares the two
    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            cal_div_ff <= `RST_CAL_DIV;
        end else if (wr_en && wr_addr == `ADDR_CAL_DIV) begin
            cal_div_ff <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            fb_div_ff <= `RST_FB_DIV;
        end else if (wr_en && wr_addr == `ADDR_FB_DIV) begin
            fb_div_ff <= wr_data;
        end
    end

    // lock bit always writable
    // a soft reset cannot reach this while locked, as wr_en gates it
    always_ff @(posedge clk) begin
        if (!reset_n || load_defaults) begin
            wlock_ff <= `RST_WRITE_LOCK;
        end else if (wr_en && wr_addr == `ADDR_WRITE_LOCK) begin
            wlock_ff <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pol_d_ff   <= 1'b1;
            sw_sync_ff <= 1'b0;
        end else begin
            pol_d_ff   <= sync_ctrl_ff[`SYNC_POL_BIT];
            sw_sync_ff <= pol_d_ff != sync_ctrl_ff[`SYNC_POL_BIT];
        end
    end

    // lock detect counter
    // counts phase detector ticks; any excursion restarts the wait
    // the flag rises on the tick after the count reaches the field
    assign lock_target = cp_lock_ff[19:6];
    always_ff @(posedge clk) begin
        if (!reset_n || !phase_in_window || load_defaults) begin
            lock_cnt_ff <= 14'h0000;
            lock_ff     <= 1'b0;
        end else if (pd_tick) begin
            if (lock_cnt_ff >= lock_target) begin
                lock_ff <= 1'b1;
            end else begin
                lock_cnt_ff <= lock_cnt_ff + 14'h0001;
            end
        end
    end

    // reference, prescaler and feedback divider range check
    // out of range values are stored anyway and only flagged
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_err_ff <= 1'b0;
        end else begin
            div_err_ff <= (ref_div_ff[31:20] == 12'h000) ||
                          (fb_div_ff[26:24] < 3'h2) ||
                          (fb_div_ff[22:5] == 18'h0_0000);
        end
    end

    assign sync_active = sync_request || sw_sync_ff ||
                         (lock_pin_ff[`HOLD_SYNC_BIT] && !lock_ff);

    assign osc_buffer_control          = osc_buf_ff;
    assign sync_and_osc_input_control  = sync_ctrl_ff;
    assign lock_detect_pin_control     = lock_pin_ff;
    assign readback_and_gp0_control    = rb_gp0_ff;
    assign gp1_output_control          = gp1_ff;
    assign loop_filter_settings        = loop_ff;
    assign charge_pump_and_lock_count  = cp_lock_ff;
    assign reference_divider           = ref_div_ff;
    assign input_range_and_cal_divider = cal_div_ff;
    assign feedback_divider            = fb_div_ff;
    assign write_lock_control          = wlock_ff;
    assign soft_reset_active           = soft_rst_ff;
    assign digital_lock                = lock_ff;
    assign sw_sync_pulse               = sw_sync_ff;
    assign divider_config_error        = div_err_ff;
endmodule

// file: sim/serial_host_model.sv
`timescale 1ns/1ps
// host side of the three-wire write port
module serial_host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_latch
);
    // idle: serial clock parked low, latch released
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b1;
    end
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            ser_latch = 1'b0;
            ser_data = w[i];
            repeat (4) @(negedge clk);
            ser_clk = 1'b1;
            repeat (4) @(negedge clk);
            ser_clk = 1'b0;
        end
        repeat (2) @(negedge clk);
        ser_latch = 1'b1;
        // data no longer meaningful once the frame is over
        ser_data = ~w[0];
        repeat (6) @(negedge clk);
    endtask
endmodule

// file: sim/clock_gen_upper_config_regs_chk.sv
`timescale 1ns/1ps
// watches register outputs and lock/sync controls
module clock_gen_upper_config_regs_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // pll status
    input wire logic        pd_tick,
    input wire logic        phase_in_window,
    // registers
    input wire logic [31:0] osc_buffer_control,
    input wire logic [31:0] sync_and_osc_input_control,
    input wire logic [31:0] lock_detect_pin_control,
    input wire logic [31:0] loop_filter_settings,
    input wire logic [31:0] charge_pump_and_lock_count,
    input wire logic [31:0] reference_divider,
    input wire logic [31:0] feedback_divider,
    input wire logic [31:0] write_lock_control,
    // derived controls
    input wire logic        soft_reset_active,
    input wire logic        digital_lock,
    input wire logic        sync_active,
    input wire logic        sw_sync_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // defaults seen on the first edge after reset release
    property p_osc_def;
        $rose(reset_n) |-> osc_buffer_control[27:20] == 8'h14;
    endproperty
    a_osc_def: assert property (p_osc_def)
        else $error("osc buffer default wrong");
    property p_sync_def;
        $rose(reset_n) |-> sync_and_osc_input_control[25:20] == 6'h18
            && sync_and_osc_input_control[16] && !sync_and_osc_input_control[5];
    endproperty
    a_sync_def: assert property (p_sync_def)
        else $error("sync control default wrong");
    property p_ld_def;
        $rose(reset_n) |-> lock_detect_pin_control[31:27] == 5'h03
            && !lock_detect_pin_control[23];
    endproperty
    a_ld_def: assert property (p_ld_def)
        else $error("lock pin default wrong");
    property p_cp_def;
        $rose(reset_n) |-> {loop_filter_settings[31:24],
            loop_filter_settings[22:20], loop_filter_settings[18:16]} == 0
            && charge_pump_and_lock_count[29:26] == 4'h3
            && charge_pump_and_lock_count[19:6] == 14'h2000;
    endproperty
    a_cp_def: assert property (p_cp_def)
        else $error("pll control default wrong");
    property p_div_def;
        $rose(reset_n) |-> reference_divider[31:20] == 12'h004
            && feedback_divider[26:5] == 22'h10_0030;
    endproperty
    a_div_def: assert property (p_div_def)
        else $error("divider default wrong");
    property p_wlock;
        write_lock_control[5] && $past(write_lock_control[5])
            |-> $stable(osc_buffer_control) && $stable(feedback_divider);
    endproperty
    a_wlock: assert property (p_wlock)
        else $error("locked register changed");
    property p_soft;
        $rose(soft_reset_active) |-> ##[0:1] reference_divider[31:20]
            == 12'h004 && !write_lock_control[5];
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset did not reload");
    property p_lock_rise;
        $rose(digital_lock) |-> $past(pd_tick) && $past(phase_in_window);
    endproperty
    a_lock_rise: assert property (p_lock_rise)
        else $error("lock rose without tick");
    property p_lock_drop;
        !phase_in_window |=> !digital_lock;
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("lock kept outside window");
    property p_hold;
        lock_detect_pin_control[23] && !digital_lock |-> sync_active;
    endproperty
    a_hold: assert property (p_hold)
        else $error("sync not held before lock");
    property p_swsync;
        $changed(sync_and_osc_input_control[16]) |-> ##[0:2] sw_sync_pulse;
    endproperty
    a_swsync: assert property (p_swsync)
        else $error("no software sync pulse");
    c_lock: cover property (digital_lock);
    c_soft: cover property (soft_reset_active);
    c_wlock: cover property (write_lock_control[5]);
endmodule
bind clock_gen_upper_config_regs clock_gen_upper_config_regs_chk u_chk (
    .clk, .reset_n, .pd_tick, .phase_in_window, .osc_buffer_control,
    .sync_and_osc_input_control, .lock_detect_pin_control,
    .loop_filter_settings, .charge_pump_and_lock_count, .reference_divider,
    .feedback_divider, .write_lock_control, .soft_reset_active,
    .digital_lock, .sync_active, .sw_sync_pulse
);

// file: sim/clock_gen_upper_config_regs_bench.sv
`timescale 1ns/1ps
`include "clock_gen_defines.svh"
module clock_gen_upper_config_regs_bench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        pd_tick = 1'b0;
    logic        phase_in_window = 1'b0;
    logic        sync_request = 1'b0;
    logic        ser_clk, ser_data, ser_latch;
    logic        soft_reset_active, digital_lock, sync_active, sw_sync_pulse;
    logic        div_err;
    logic [31:0] dout [11];
    logic [31:0] mdl [11];
    logic [31:0] dflt [11];
    logic [4:0]  adr [11];
    logic [31:0] r;
    logic [31:0] rng = 32'h59e8_9805;
    bit          sr = 1'b0;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          pulses = 0;
    // clock and device
    always #2.5 clk = ~clk;
    serial_host_model u_host (.clk, .ser_clk, .ser_data, .ser_latch);
    clock_gen_upper_config_regs u_dut (.clk, .reset_n, .ser_clk, .ser_data,
        .ser_latch, .pd_tick, .phase_in_window, .sync_request,
        .osc_buffer_control(dout[0]), .sync_and_osc_input_control(dout[1]),
        .lock_detect_pin_control(dout[2]), .readback_and_gp0_control(dout[3]),
        .gp1_output_control(dout[4]), .loop_filter_settings(dout[5]),
        .charge_pump_and_lock_count(dout[6]), .reference_divider(dout[7]),
        .input_range_and_cal_divider(dout[8]), .feedback_divider(dout[9]),
        .write_lock_control(dout[10]), .soft_reset_active, .digital_lock,
        .sync_active, .sw_sync_pulse, .divider_config_error(div_err));
    // count software sync pulses
    always @(posedge clk) if (sw_sync_pulse === 1'b1) pulses++;
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_all();
        bit bad;
        // divider ranges: reference 1 up, prescaler 2 up, feedback 1 up
        bad = mdl[7][31:20] == 12'h000 || mdl[9][26:24] < 3'h2 ||
              mdl[9][22:5] == 18'h0_0000;
        for (int k = 0; k < 11; k++) check(dout[k], mdl[k]);
        check({31'h0, soft_reset_active}, {31'h0, sr});
        check({31'h0, div_err}, {31'h0, bad});
    endtask
    // one frame, then update the reference copy
    task automatic wr(input logic [4:0] a, input logic [26:0] d);
        int k;
        k = -1;
        for (int i = 0; i < 11; i++) if (adr[i] == a) k = i;
        @(negedge clk);
        u_host.send({d, a});
        if (!mdl[10][5] || a == 5'h1f) begin
            if (a == 5'h00 && d[12]) begin
                mdl = dflt;
                sr = 1'b1;
            end else begin
                // any other accepted write clears the flag
                sr = 1'b0;
                if (k >= 0) mdl[k] = {d, 5'h00};
            end
        end
        repeat (6) @(negedge clk);
        chk_all();
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            pd_tick = 1'b1;
            @(negedge clk);
            pd_tick = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog for a hung frame
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    // main sequence
    initial begin
        dflt = '{`RST_OSC_BUF, `RST_SYNC_CTRL, `RST_LOCK_PIN,
            `RST_READBACK_GP0, `RST_GP1, `RST_LOOP_FILTER, `RST_CP_LOCK,
            `RST_REF_DIV, `RST_CAL_DIV, `RST_FB_DIV, `RST_WRITE_LOCK};
        adr = '{5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h18, 5'h1a, 5'h1c,
            5'h1d, 5'h1e, 5'h1f};
        mdl = dflt;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        chk_all();
        $display("defaults done");
        wr(5'h03, 27'h000_0001);
        // random traffic plus unmapped addresses
        repeat (8) begin
            r = xs();
            wr(adr[r[3:0] % 10], r[31:5]);
        end
        wr(5'h05, r[26:0]);
        wr(5'h00, 27'h000_0000);
        $display("random done");
        // divider range ends, then host sets calibration equal to feedback
        wr(5'h1c, {12'hfff, 15'h0000});
        wr(5'h1c, {12'h001, 15'h0000});
        wr(5'h1e, {5'h00, 3'h1, 1'b0, 18'h0_0030});
        check({31'h0, div_err}, 32'h0000_0001);
        wr(5'h1e, {5'h00, 3'h2, 1'b0, 18'h3_ffff});
        wr(5'h1d, {5'h00, 3'h7, 1'b0, 18'h3_ffff});
        $display("ranges done");
        r = pulses;
        wr(5'h0b, mdl[1][31:5] ^ 27'h000_0800);
        check(pulses - r, 32'h0000_0001);
        wr(5'h0c, mdl[2][31:5] | 27'h004_0000);
        check({31'h0, sync_active}, 32'h0000_0001);
        $display("sync done");
        r = {mdl[6][31:20], 14'h0005, mdl[6][5:0]};
        wr(5'h1a, r[31:5]);
        phase_in_window = 1'b1;
        ticks(4);
        check({31'h0, digital_lock}, 32'h0000_0000);
        ticks(3);
        check({31'h0, digital_lock}, 32'h0000_0001);
        check({31'h0, sync_active}, 32'h0000_0000);
        sync_request = 1'b1;
        @(negedge clk);
        check({31'h0, sync_active}, 32'h0000_0001);
        sync_request = 1'b0;
        phase_in_window = 1'b0;
        repeat (2) @(negedge clk);
        check({31'h0, digital_lock}, 32'h0000_0000);
        $display("lock done");
        wr(5'h1f, 27'h000_0001);
        wr(5'h0a, 27'h000_0000);
        wr(5'h00, 27'h000_1000);
        wr(5'h1f, 27'h000_0000);
        $display("write lock done");
        wr(5'h00, 27'h000_1000);
        wr(5'h18, r[26:0]);
        $display("soft reset done");
        close_out();
    end
endmodule
